// ### dwc_cfg.svh
// Constants for the data watchpoint control block
`ifndef DWC_CFG_SVH
`define DWC_CFG_SVH
`define DWC_OP1_WATCH 3'h0
`define DWC_CRN_WATCH 4'h0
`define DWC_OP2_VALUE 3'h6
`define DWC_OP2_CTRL 3'h7
`define DWC_PAIRS 2
`define DWC_LINK_EN_BIT 20
`define DWC_LINK_HI 19
`define DWC_LINK_LO 16
`define DWC_BYTE_HI 8
`define DWC_BYTE_LO 5
`define DWC_LS_HI 4
`define DWC_LS_LO 3
`define DWC_PRIV_HI 2
`define DWC_PRIV_LO 1
`define DWC_ENABLE_BIT 0
`define DWC_LINK_BP4 4'h4
`define DWC_LINK_BP5 4'h5
`define DWC_MON_MODE 2'h2
`define DWC_CTRL_MASK 32'h001F01FF
`define DWC_VALUE_MASK 32'hFFFFFFFC
`define DWC_CTRL_RESET 32'h00000000
`define DWC_VALUE_RESET 32'h00000000
`define DWC_BCR_MATCH_CTX 2'h3
`define DWC_SYNC_DELAY 4'h3
`endif

// ### dwc_pkg.sv
// Types for the data watchpoint control block
package dwc_pkg;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [3:0] lanes;
        logic is_load;
        logic is_store;
        logic privileged;
        logic [7:0] context_id;
    } dwc_access_s;
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic privileged;
        logic [31:0] wdata;
    } dwc_coproc_s;
    typedef struct packed {
        logic ctx_match4;
        logic ctx_match5;
        logic enable4;
        logic enable5;
        logic [1:0] match_type4;
        logic [1:0] match_type5;
    } dwc_brk_s;
    typedef enum logic [1:0] {
        DWC_IDLE = 2'b00,
        DWC_WAIT = 2'b01
    } dwc_sync_e;
endpackage

// ### dwc_match.sv
// One watchpoint comparator
`timescale 1ns/1ns
`include "dwc_cfg.svh"
module dwc_match (
    input wire dwc_pkg::dwc_access_s acc_in,
    input wire logic [31:0] ctrl_in,
    input wire logic [31:0] value_in,
    input wire dwc_pkg::dwc_brk_s brk_in,
    output logic hit_out
);
    import dwc_pkg::*;
    logic [1:0] ls;
    logic [1:0] priv;
    logic [3:0] bsel;
    logic [3:0] link;
    logic type_ok;
    logic priv_ok;
    logic addr_ok;
    logic ctx_ok;
    always_comb begin
        ls = ctrl_in[`DWC_LS_HI:`DWC_LS_LO];
        priv = ctrl_in[`DWC_PRIV_HI:`DWC_PRIV_LO];
        bsel = ctrl_in[`DWC_BYTE_HI:`DWC_BYTE_LO];
        link = ctrl_in[`DWC_LINK_HI:`DWC_LINK_LO];
        // Swap sets both kinds; exclusives set one, store regardless of success
        type_ok = (acc_in.is_load && ls[0]) || (acc_in.is_store && ls[1]);
        priv_ok = acc_in.privileged ? priv[0] : priv[1];
        addr_ok = (acc_in.addr[31:2] == value_in[31:2]) && ((acc_in.lanes & bsel) != 4'h0);
        ctx_ok = 1'b1;
        if (ctrl_in[`DWC_LINK_EN_BIT]) begin
            // Several pairs may read the same context result at once
            if (link == `DWC_LINK_BP4) begin
                ctx_ok = brk_in.enable4 && brk_in.ctx_match4;
            end else if (link == `DWC_LINK_BP5) begin
                ctx_ok = brk_in.enable5 && brk_in.ctx_match5;
            end else begin
                // Unpermitted link targets never hit
                ctx_ok = 1'b0;
            end
        end
        hit_out = acc_in.valid && ctrl_in[`DWC_ENABLE_BIT] && type_ok && priv_ok && addr_ok
            && ctx_ok;
    end
endmodule

// ### dwc_top.sv
// Data watchpoint control: coprocessor registers and event generation
`timescale 1ns/1ns
`include "dwc_cfg.svh"
module dwc_top (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire dwc_pkg::dwc_access_s acc_in,
    input wire dwc_pkg::dwc_coproc_s cop_in,
    input wire dwc_pkg::dwc_brk_s brk_in,
    input wire logic [1:0] debug_mode_in,
    input wire logic debug_state_in,
    output logic cop_claim_out,
    output logic cop_done_out,
    output logic cop_undef_out,
    output logic [31:0] cop_rdata_out,
    output logic watch_event_out,
    output logic [1:0] watch_hit_out
);
    import dwc_pkg::*;
    typedef struct packed {
        // Programmed settings, as software reads them back
        logic [`DWC_PAIRS-1:0][31:0] ctrl;
        logic [`DWC_PAIRS-1:0][31:0] value;
        // Settings the comparators use; they lag the programmed ones
        logic [`DWC_PAIRS-1:0][31:0] ctrl_act;
        logic [`DWC_PAIRS-1:0][31:0] value_act;
        // Write-to-use delay
        dwc_sync_e sync;
        logic [3:0] cnt;
        // Answer to the coprocessor transfer
        logic done;
        logic undef;
        logic [31:0] rdata;
        // Registered event outputs
        logic event_q;
        logic [1:0] hit;
    } dwc_state_s;
    dwc_state_s state_reg;
    dwc_state_s state_next;

    logic [1:0] hit_raw;
    logic is_watch;
    logic is_ctrl;
    logic allowed;
    logic pair_ok;
    logic pair;

    logic wr_take;
    logic rd_take;
    logic [31:0] wr_word;
    logic [31:0] rd_word;

    function automatic logic [31:0] pick(input logic [`DWC_PAIRS-1:0][31:0] regs,
                                         input logic sel);
        pick = regs[sel];
    endfunction

    // Replace one pair's word and leave the other pair untouched
    function automatic logic [`DWC_PAIRS-1:0][31:0] put_word(
        input logic [`DWC_PAIRS-1:0][31:0] regs,
        input logic sel,
        input logic [31:0] word
    );
        put_word = regs;
        put_word[sel] = word;
    endfunction

    // Reserved bits are never stored, so they always read back as 0
    function automatic logic [31:0] keep_mask(input logic ctl);
        if (ctl) begin
            keep_mask = `DWC_CTRL_MASK;
        end else begin
            keep_mask = `DWC_VALUE_MASK;
        end
    endfunction

    // Register-number part of the decode; crm is checked apart since it picks the pair
    function automatic logic watch_code(input dwc_coproc_s cop);
        watch_code = (cop.op1 == `DWC_OP1_WATCH) && (cop.crn == `DWC_CRN_WATCH)
            && ((cop.op2 == `DWC_OP2_CTRL) || (cop.op2 == `DWC_OP2_VALUE));
    endfunction

    function automatic logic may_access(input logic priv,
                                        input logic [1:0] mode,
                                        input logic dbg);
        // Debug state overrides the monitor-mode lockout
        may_access = dbg || (priv && (mode == `DWC_MON_MODE));
    endfunction

    // One comparator per pair; all of them see the same access and break results
    genvar g;
    generate
        for (g = 0; g < `DWC_PAIRS; g++) begin : gen_pair
            dwc_match u_match (
                .acc_in(acc_in),
                .ctrl_in(state_reg.ctrl_act[g]),
                .value_in(state_reg.value_act[g]),
                .brk_in(brk_in),
                .hit_out(hit_raw[g])
            );
        end
    endgenerate

    always_comb begin
        // Claim is combinational so the core can trap the same instruction it decodes
        pair = cop_in.crm[0];
        pair_ok = (cop_in.crm[3:1] == 3'h0);
        is_watch = cop_in.valid && pair_ok && watch_code(cop_in);
        is_ctrl = (cop_in.op2 == `DWC_OP2_CTRL);
        allowed = may_access(cop_in.privileged, debug_mode_in,
            debug_state_in);
        cop_claim_out = is_watch;
        wr_take = is_watch && allowed && cop_in.write;
        rd_take = is_watch && allowed && !cop_in.write;
        wr_word = cop_in.wdata & keep_mask(is_ctrl);
        if (is_ctrl) begin
            rd_word = pick(state_reg.ctrl, pair);
        end else begin
            rd_word = pick(state_reg.value, pair);
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.undef = 1'b0;

        // Every claimed transfer gets exactly one answer, one cycle later
        if (is_watch) begin
            if (allowed) begin
                state_next.done = 1'b1;
            end else begin
                state_next.undef = 1'b1;
            end
        end

        // Reads return the programmed words, which may not be active yet
        if (wr_take) begin
            if (is_ctrl) begin
                state_next.ctrl = put_word(state_reg.ctrl, pair, wr_word);
            end else begin
                state_next.value = put_word(state_reg.value, pair, wr_word);
            end
        end
        if (rd_take) begin
            state_next.rdata = rd_word;
        end

        // New settings reach the comparators after a short delay; each write restarts it
        unique case (state_reg.sync)
            DWC_IDLE: begin
                if (wr_take) begin
                    state_next.sync = DWC_WAIT;
                    state_next.cnt = `DWC_SYNC_DELAY;
                end
            end
            DWC_WAIT: begin
                if (wr_take) begin
                    state_next.cnt = `DWC_SYNC_DELAY;
                end else if (state_reg.cnt != 4'h0) begin
                    state_next.cnt = state_reg.cnt - 4'h1;
                end else begin
                    state_next.sync = DWC_IDLE;
                end
                if (state_reg.cnt == 4'h0) begin
                    state_next.ctrl_act = state_reg.ctrl;
                    state_next.value_act = state_reg.value;
                end
            end
            default: begin
                state_next.sync = DWC_IDLE;
            end
        endcase

        // Event path: one cycle behind the access, per pair and summed
        state_next.hit = hit_raw;
        state_next.event_q = |hit_raw;

        if (!rstn_in) begin
            // Watchpoints leave reset disabled; nothing matches until software arms them
            state_next = '0;
            state_next.ctrl = {`DWC_PAIRS{`DWC_CTRL_RESET}};
            state_next.ctrl_act = {`DWC_PAIRS{`DWC_CTRL_RESET}};
            state_next.value = {`DWC_PAIRS{`DWC_VALUE_RESET}};
            state_next.value_act = {`DWC_PAIRS{`DWC_VALUE_RESET}};
            state_next.sync = DWC_IDLE;
        end
    end

    // Reset is folded into the next-state logic, so this stays a plain register
    always_ff @(posedge clk_sys_in) begin
        state_reg <= state_next;
    end

    // Every output but the claim comes straight from a flip-flop
    assign cop_done_out = state_reg.done;
    assign cop_undef_out = state_reg.undef;
    assign cop_rdata_out = state_reg.rdata;
    assign watch_event_out = state_reg.event_q;
    assign watch_hit_out = state_reg.hit;
endmodule

// ### dwc_assertions.sv
// Port checks for the data watchpoint control block
`timescale 1ns/1ns
module dwc_checker (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire dwc_pkg::dwc_access_s acc_in,
    input wire dwc_pkg::dwc_coproc_s cop_in,
    input wire logic [1:0] debug_mode_in,
    input wire logic debug_state_in,
    input wire logic cop_claim_out,
    input wire logic cop_done_out,
    input wire logic cop_undef_out,
    input wire logic [31:0] cop_rdata_out,
    input wire logic watch_event_out,
    input wire logic [1:0] watch_hit_out
);
    import dwc_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    logic dec, ok;
    assign dec = cop_in.op1 == 3'h0 && cop_in.crn == 4'h0 && cop_in.crm[3:1] == 3'h0
        && cop_in.op2[2:1] == 2'h3;
    assign ok = debug_state_in || cop_in.privileged && debug_mode_in == 2'h2;
    sequence taken_s; cop_in.valid && cop_claim_out && ok; endsequence
    sequence refused_s; cop_in.valid && cop_claim_out && !ok; endsequence
    sequence done_s; cop_done_out && !cop_undef_out; endsequence
    claim_decode_a: assert property (cop_in.valid |-> cop_claim_out == dec)
        else $error("claim differs from decode");
    done_allowed_a: assert property (taken_s |=> done_s)
        else $error("allowed access not done");
    undef_refused_a: assert property (refused_s |=> cop_undef_out && !cop_done_out)
        else $error("refused access not flagged");
    idle_quiet_a: assert property (!(cop_in.valid && cop_claim_out)
        |=> !cop_done_out && !cop_undef_out) else $error("answer without request");
    event_sum_a: assert property (watch_event_out == |watch_hit_out)
        else $error("event differs from hits");
    no_access_a: assert property (!acc_in.valid |=> watch_hit_out == 2'h0)
        else $error("hit without access");
    no_lanes_a: assert property (acc_in.lanes == 4'h0 |=> !watch_event_out)
        else $error("hit without lanes");
    no_type_a: assert property (!acc_in.is_load && !acc_in.is_store |=> !watch_event_out)
        else $error("hit without load or store");
    rdata_hold_a: assert property (!cop_done_out |-> $stable(cop_rdata_out))
        else $error("read data moved");
endmodule
bind dwc_top dwc_checker chk_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .acc_in(acc_in), .cop_in(cop_in), .debug_mode_in(debug_mode_in),
    .debug_state_in(debug_state_in), .cop_claim_out(cop_claim_out),
    .cop_done_out(cop_done_out), .cop_undef_out(cop_undef_out),
    .cop_rdata_out(cop_rdata_out), .watch_event_out(watch_event_out),
    .watch_hit_out(watch_hit_out));

// ### dwc_brk_model.sv
// Model of the two context-capable break pairs
`timescale 1ns/1ns
`include "dwc_cfg.svh"
module dwc_brk_model (
    input wire logic [7:0] ctx_in,
    input wire logic [7:0] id4_in,
    input wire logic [7:0] id5_in,
    input wire logic en4_in,
    input wire logic en5_in,
    output dwc_pkg::dwc_brk_s brk_out
);
    import dwc_pkg::*;
    // Only pairs 4 and 5 compare context; every watch pair sees the same result
    assign brk_out = '{ctx_in == id4_in, ctx_in == id5_in, en4_in, en5_in,
        `DWC_BCR_MATCH_CTX, `DWC_BCR_MATCH_CTX};
endmodule

// ### dwc_top_test.sv
// Self-checking testbench for the data watchpoint control block
`timescale 1ns/1ns
`include "dwc_cfg.svh"
module dwc_top_test;
    import dwc_pkg::*;
    logic clk_sys_in = 0, rstn_in = 0, ds = 0, en4 = 0, en5 = 0, claim, done, undef, ev;
    logic [1:0] md = 2'h2, hit;
    logic [7:0] id4 = 8'h00, id5 = 8'h00;
    logic [31:0] rd, c, sh [4] = '{default: 0}, act [4] = '{default: 0};
    dwc_access_s acc = '0;
    dwc_coproc_s cop = '0;
    dwc_brk_s brk;
    int err_count = 0, n_tests = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    dwc_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .acc_in(acc), .cop_in(cop),
        .brk_in(brk), .debug_mode_in(md), .debug_state_in(ds), .cop_claim_out(claim),
        .cop_done_out(done), .cop_undef_out(undef), .cop_rdata_out(rd),
        .watch_event_out(ev), .watch_hit_out(hit));
    dwc_brk_model pm (.ctx_in(acc.context_id), .id4_in(id4), .id5_in(id5), .en4_in(en4),
        .en5_in(en5), .brk_out(brk));
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cp(input logic wr, pr, input logic [3:0] cm, input logic [2:0] o2,
        input logic [31:0] d, input logic [1:0] want);
        @(posedge clk_sys_in);
        #1 cop = '{1'b1, wr, 3'h0, 4'h0, cm, o2, pr, d};
        #4 chk(32'(claim), 32'(cm[3:1] == 3'h0 && o2[2:1] == 2'h3));
        @(posedge clk_sys_in);
        #1 cop.valid = 0;
        chk(32'({done, undef}), 32'(want));
    endtask
    // Index 0/1 value registers, 2/3 control registers
    task automatic wreg(input logic [1:0] i, input logic [31:0] d);
        cp(1, 1, {3'h0, i[0]}, {2'h3, i[1]}, d, 2'b10);
        sh[i] = d & (i[1] ? `DWC_CTRL_MASK : `DWC_VALUE_MASK);
    endtask
    task automatic rreg(input logic [1:0] i);
        cp(0, 1, {3'h0, i[0]}, {2'h3, i[1]}, $urandom, 2'b10);
        chk(rd, sh[i]);
    endtask
    // Writes land late, so expectations follow only after the settle gap
    task automatic settle;
        repeat (5) @(posedge clk_sys_in);
        act = sh;
    endtask
    function automatic logic ex(input int i);
        logic [31:0] k = act[i + 2], v = act[i];
        logic lk = k[19:16] == 4'h4 ? en4 && acc.context_id == id4
            : k[19:16] == 4'h5 && en5 && acc.context_id == id5;
        return k[0] && v[31:2] == acc.addr[31:2] && |(k[8:5] & acc.lanes)
            && (k[3] & acc.is_load | k[4] & acc.is_store)
            && (acc.privileged ? k[1] : k[2]) && (!k[20] || lk);
    endfunction
    task automatic ac(input logic [31:0] a, input logic [3:0] l, input logic [2:0] t,
        input logic [7:0] cx);
        logic [1:0] e;
        @(posedge clk_sys_in);
        #1 acc = '{1'b1, a, l, t[0], t[1], t[2], cx};
        e = {ex(1), ex(0)};
        @(posedge clk_sys_in);
        #1 acc.valid = 0;
        chk(32'({ev, hit}), 32'({|e, e}));
    endtask
    initial begin
        void'($urandom(74));
        repeat (3) @(posedge clk_sys_in);
        #1 rstn_in = 1;
        chk(32'({done, undef, ev, hit}), 32'h0);
        rreg(2);
        cp(1, 1, 4'h2, 3'h7, 32'h0, 2'b00);
        cp(1, 1, 4'h0, 3'h5, 32'h0, 2'b00);
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            cp(0, 1, 4'h1, 3'h7, 32'h0, m == 2 ? 2'b10 : 2'b01);
            cp(0, 0, 4'h1, 3'h6, 32'h0, 2'b01);
            ds = 1;
            cp(0, 1, 4'h1, 3'h7, 32'h0, 2'b10);
            ds = 0;
        end
        md = 2'h2;
        wreg(0, 32'h0000_1000);
        wreg(2, 32'h0000_01FF);
        ac(32'h0000_1000, 4'hF, 3'h7, 8'h00);
        settle;
        ac(32'h0000_1003, 4'h8, 3'h2, 8'h00);
        for (int r = 0; r < 60; r++) begin
            c = $urandom;
            if (c[20]) c[19:17] = 3'h2;
            wreg(2'(2 + r % 2), c | 32'(r % 3 > 0));
            wreg(2'(r % 2), $urandom);
            rreg(2'(2 + r % 2));
            rreg(2'(r % 2));
            {id4, id5, en4, en5} = 18'($urandom);
            settle;
            for (int j = 0; j < 6; j++) begin
                c = $urandom;
                ac(j < 4 ? act[c[0]] ^ 32'(c[2:1]) : c, c[7:4], c[10:8],
                    c[11] ? id4 : c[12] ? id5 : c[20:13]);
            end
        end
        conclude;
    end
endmodule
